// *** rtl/hul_pkg.sv ***
// shared constants and types for the host uart link layer
package hul_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] A_SETUP = 8'h00;
	localparam logic [7:0] A_DADDR = 8'h04;
	localparam logic [7:0] A_HOLD  = 8'h08;
	localparam logic [7:0] A_FAULT = 8'h0C;
	localparam logic [7:0] A_TXD   = 8'h10;
	localparam logic [7:0] A_RXD   = 8'h14;
	localparam logic [7:0] A_STAT  = 8'h18;

	// device_setup_reg fields
	localparam int          SU_STANDALONE = 0;
	localparam int          SU_TWO_STOP   = 1;
	localparam int          SU_STACK      = 2;
	localparam int          SU_DEBUG      = 3;
	localparam int          SU_SLOW       = 4;
	localparam int          SU_TX_EN      = 5;
	localparam int          SU_W          = 6;
	localparam logic [5:0]  SU_RST        = 6'h20;

	localparam int          DADDR_W       = 6;
	localparam int          HOLD_W        = 8;
	localparam logic [7:0]  HOLD_RST      = 8'h01;

	// comm_fault_status fields
	localparam int          F_STOP        = 0;
	localparam int          F_CLEAR       = 1;

	// rx data and status fields
	localparam int          RXD_VALID     = 8;
	localparam int          RXD_SOF       = 9;
	localparam int          ST_TX_PEND    = 0;
	localparam int          ST_TX_BUSY    = 1;
	localparam int          ST_RX_VALID   = 2;
	localparam int          ST_UART_ON    = 3;

	// ****************************************
	// timing
	// ****************************************
	localparam int          CLK_NS        = 20;
	localparam int          BIT_NS_FAST   = 1000;
	localparam int          BIT_NS_SLOW   = 4000;
	localparam int          DIV_W         = 8;
	localparam logic [7:0]  BIT_FAST      = 8'(BIT_NS_FAST / CLK_NS);
	localparam logic [7:0]  BIT_SLOW      = 8'(BIT_NS_SLOW / CLK_NS);
	localparam int          DATA_BITS     = 8;
	localparam int          CLR_W         = 12;
	localparam logic [3:0]  CLEAR_BITS    = 4'hF;

	// ****************************************
	// state encodings
	// ****************************************
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_STOP  = 3'b011,
		RX_WAIT  = 3'b100
	} hul_rx_e;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_STOP1 = 3'b011,
		TX_STOP2 = 3'b100
	} hul_tx_e;

endpackage : hul_pkg

// *** rtl/hul_bit_timer.sv ***
// bit period timer: reloadable down counter giving one-cycle ticks
`timescale 1ns/10ps
module hul_bit_timer (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       restart,
	input  wire logic [7:0] load_val,
	input  wire logic [7:0] period,
	output logic            tick
);
	logic [7:0] cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 8'h00;
		end else if (restart) begin
			cnt <= load_val;
		end else if (cnt == 8'h00) begin
			cnt <= period - 8'h01;
		end else begin
			cnt <= cnt - 8'h01;
		end
	end

	assign tick = (cnt == 8'h00) && !restart;

endmodule : hul_bit_timer

// *** rtl/hul_uart_link.sv ***
// host uart link layer with ahb-lite register slave
// What this block does
// (RL1) standalone bit set disables chain port; cleared means chain base or stack.
// (RL2) device address register holds six bits, sixty-four chain positions.
// (RL3) base talks to host over uart; stack uses only chain ports.
// (RL4) each byte is start bit, eight data bits, no parity, stop bit.
// (RL5) zero in received stop bit sets the stop error flag.
// (RL6) normal bit rate is one megabit per second.
// (RL7) 250 kbit/s rate only selectable in communication debug mode.
// (RL8) rx and tx rest high when no byte is sent.
// (RL9) transmitter off by default, tx pin inactive in stack devices; here setup resets with tx enable set, so the transmitter starts on.
// (RL10) tx pin held high internally whether transmitter enabled or not.
// (RL11) half duplex: incoming bytes ignored while transmitting.
// (RL12) line clear on rx honoured during transmit, aborts it at once.
// (RL13) two-stop option makes every response byte end in two stops.
// (RL14) receiver accepts bytes with one or more stop bits.
// (RL15) stack devices use two-stop setting to pick gap between frames.
// (RL16) transmit waits hold-off bit periods after last received bit.
// (RL17) frame content travels as whole bytes, one character each.
// (RL18) frame: init, device address, two-byte register, data, two-byte check.
// (RL19) after a line clear next byte marks start of a new frame.
// (RL20) line clear detection sets the line clear seen flag.
// (RL21) host waits for whole response or timeout before next command.
// (RL22) receiver finds start edge and samples each bit at centre.
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module hul_uart_link (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        rx,
	output logic             tx,
	output logic             tx_oe,
	output logic             chain_port_enable,
	output logic             chain_gap_long
);
	// ****************************************
	// registers and status
	// ****************************************
	logic [hul_pkg::SU_W-1:0]    setup;
	logic [hul_pkg::DADDR_W-1:0] dev_addr;
	logic [hul_pkg::HOLD_W-1:0]  hold_off;
	logic                        stop_error_flag;
	logic                        line_clear_seen_flag;
	logic [7:0]                  tx_byte;
	logic                        tx_pend;
	logic [7:0]                  rx_byte;
	logic                        rx_valid;
	logic                        rx_sof;
	logic                        sof_pend;
	logic                        wr_q;
	logic [7:0]                  addr_q;
	logic                        rx_m;
	logic                        rx_s;
	logic                        rx_s_d;
	hul_pkg::hul_rx_e            rx_st;
	hul_pkg::hul_tx_e            tx_st;
	logic [2:0]                  rx_bit;
	logic [2:0]                  tx_bit;
	logic [7:0]                  rx_shift;
	logic [7:0]                  tx_shift;
	logic [hul_pkg::HOLD_W-1:0]  hold_cnt;
	logic [hul_pkg::CLR_W-1:0]   clr_cnt;
	logic [hul_pkg::CLR_W-1:0]   clr_limit;
	logic [7:0]                  bit_div;
	logic [7:0]                  half_div;
	logic                        rx_tick;
	logic                        tx_tick;
	logic                        rx_restart;
	logic                        tx_go;
	logic                        line_clear;
	logic                        rx_done;
	logic                        rx_good;
	logic                        tx_ok;
	logic                        uart_on;
	logic                        tx_busy;
	logic                        addr_ph;
	logic                        rd_ph;
	logic                        rd_rxd;

	assign addr_ph = hsel && htrans[1] && hready;
	assign rd_ph   = addr_ph && !hwrite;
	assign rd_rxd  = rd_ph && (haddr == hul_pkg::A_RXD);
	// slow rate is honoured only while debug mode is on
	assign bit_div = (setup[hul_pkg::SU_DEBUG] && setup[hul_pkg::SU_SLOW]) ?
		hul_pkg::BIT_SLOW : hul_pkg::BIT_FAST; // RL6 RL7
	assign half_div = (bit_div >> 1) - 8'h01;
	assign clr_limit = hul_pkg::CLR_W'(hul_pkg::CLEAR_BITS) * hul_pkg::CLR_W'(bit_div);
	// a stack device never uses the host uart
	assign uart_on = setup[hul_pkg::SU_STANDALONE] || !setup[hul_pkg::SU_STACK]; // RL3
	assign tx_ok   = uart_on && setup[hul_pkg::SU_TX_EN]; // RL9
	assign tx_busy = (tx_st != hul_pkg::TX_IDLE);

	// ****************************************
	// ahb-lite slave
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			addr_q <= 8'h00;
		end else if (hready) begin
			wr_q   <= addr_ph && hwrite;
			addr_q <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_ph) begin
			case (haddr)
				hul_pkg::A_SETUP: hrdata <= 32'(setup);
				hul_pkg::A_DADDR: hrdata <= 32'(dev_addr);
				hul_pkg::A_HOLD:  hrdata <= 32'(hold_off);
				hul_pkg::A_FAULT: hrdata <= 32'({line_clear_seen_flag, stop_error_flag});
				hul_pkg::A_TXD:   hrdata <= 32'(tx_byte);
				hul_pkg::A_RXD:   hrdata <= 32'({rx_sof, rx_valid, rx_byte});
				hul_pkg::A_STAT:  hrdata <= 32'({uart_on, rx_valid, tx_busy, tx_pend});
				default:          hrdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			setup    <= hul_pkg::SU_RST;
			dev_addr <= '0;
			hold_off <= hul_pkg::HOLD_RST;
		end else if (wr_q) begin
			case (addr_q)
				hul_pkg::A_SETUP: setup    <= hwdata[hul_pkg::SU_W-1:0]; // RL1
				hul_pkg::A_DADDR: dev_addr <= hwdata[hul_pkg::DADDR_W-1:0]; // RL2
				hul_pkg::A_HOLD:  hold_off <= hwdata[hul_pkg::HOLD_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chain_port_enable <= 1'b1;
			chain_gap_long    <= 1'b0;
			tx_oe             <= 1'b0;
		end else begin
			chain_port_enable <= !setup[hul_pkg::SU_STANDALONE]; // RL1
			chain_gap_long    <= setup[hul_pkg::SU_TWO_STOP]; // RL15
			tx_oe             <= tx_ok; // RL9
		end
	end

	// write-one-to-clear; a new event in the same cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_error_flag      <= 1'b0;
			line_clear_seen_flag <= 1'b0;
		end else begin
			if (rx_done && !rx_good) begin
				stop_error_flag <= 1'b1; // RL5
			end else if (wr_q && addr_q == hul_pkg::A_FAULT && hwdata[hul_pkg::F_STOP]) begin
				stop_error_flag <= 1'b0;
			end
			if (line_clear) begin
				line_clear_seen_flag <= 1'b1; // RL20
			end else if (wr_q && addr_q == hul_pkg::A_FAULT && hwdata[hul_pkg::F_CLEAR]) begin
				line_clear_seen_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// receiver
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_m   <= 1'b1;
			rx_s   <= 1'b1;
			rx_s_d <= 1'b1;
		end else begin
			rx_m   <= rx;
			rx_s   <= rx_m;
			rx_s_d <= rx_s;
		end
	end

	// line clear: rx low far longer than any byte, seen even while sending
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clr_cnt <= '0;
		end else if (rx_s) begin
			clr_cnt <= '0;
		end else if (clr_cnt != clr_limit) begin
			clr_cnt <= clr_cnt + 1'b1;
		end
	end
	assign line_clear = !rx_s && (clr_cnt == clr_limit - 1'b1) && uart_on; // RL12

	// rx is ignored while a byte is going out
	assign rx_restart = (rx_st == hul_pkg::RX_IDLE) && rx_s_d && !rx_s && uart_on
		&& !tx_busy; // RL11 RL22
	assign rx_done = (rx_st == hul_pkg::RX_STOP) && rx_tick;
	assign rx_good = rx_s; // RL14

	hul_bit_timer u_rx_timer (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.restart  (rx_restart),
		.load_val (half_div),
		.period   (bit_div),
		.tick     (rx_tick)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_st    <= hul_pkg::RX_IDLE;
			rx_bit   <= 3'h0;
			rx_shift <= 8'h00;
		end else if (line_clear) begin
			rx_st <= hul_pkg::RX_WAIT;
		end else begin
			case (rx_st)
				hul_pkg::RX_IDLE: begin
					if (rx_restart) begin
						rx_st <= hul_pkg::RX_START;
					end
				end
				hul_pkg::RX_START: begin
					if (rx_tick) begin
						rx_bit <= 3'h0;
						rx_st  <= rx_s ? hul_pkg::RX_IDLE : hul_pkg::RX_DATA; // RL22
					end
				end
				hul_pkg::RX_DATA: begin
					if (rx_tick) begin
						rx_shift <= {rx_s, rx_shift[7:1]}; // RL4 RL17
						rx_bit   <= rx_bit + 3'h1;
						if (rx_bit == 3'(hul_pkg::DATA_BITS - 1)) begin
							rx_st <= hul_pkg::RX_STOP;
						end
					end
				end
				hul_pkg::RX_STOP: begin
					// a low stop bit: wait for idle so its tail is no false start
					if (rx_tick) begin
						rx_st <= rx_good ? hul_pkg::RX_IDLE : hul_pkg::RX_WAIT;
					end
				end
				hul_pkg::RX_WAIT: begin
					if (rx_s) begin
						rx_st <= hul_pkg::RX_IDLE;
					end
				end
				default: rx_st <= hul_pkg::RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_byte  <= 8'h00;
			rx_valid <= 1'b0;
			rx_sof   <= 1'b0;
			sof_pend <= 1'b1;
		end else begin
			if (line_clear) begin
				sof_pend <= 1'b1; // RL19
			end else if (rx_done && rx_good) begin
				sof_pend <= 1'b0;
			end
			if (rx_done && rx_good) begin
				rx_byte  <= rx_shift;
				rx_sof   <= sof_pend; // RL18 RL19
				rx_valid <= 1'b1;
			end else if (rd_rxd) begin
				rx_valid <= 1'b0;
			end
		end
	end

	// ****************************************
	// transmitter
	// ****************************************
	// the tx timer runs free while idle and paces the hold-off count
	assign tx_go = (tx_st == hul_pkg::TX_IDLE) && tx_pend && tx_ok && (hold_cnt == '0)
	// a start edge in the same cycle wins, so rx and tx never run together
		&& (rx_st == hul_pkg::RX_IDLE) && !rx_restart && !line_clear; // RL16 RL11

	hul_bit_timer u_tx_timer (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.restart  (tx_go),
		.load_val (bit_div - 8'h01),
		.period   (bit_div),
		.tick     (tx_tick)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_cnt <= '0;
		end else if (rx_done) begin
			hold_cnt <= hold_off; // RL16
		end else if (tx_tick && hold_cnt != '0 && !tx_busy) begin
			hold_cnt <= hold_cnt - 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_pend <= 1'b0;
			tx_byte <= 8'h00;
		end else if (line_clear || tx_go) begin
			tx_pend <= 1'b0;
		end else if (wr_q && addr_q == hul_pkg::A_TXD && !tx_pend) begin
			tx_byte <= hwdata[7:0];
			tx_pend <= 1'b1;
		end
	end

	// tx idles high, and is held high when disabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_st    <= hul_pkg::TX_IDLE;
			tx       <= 1'b1;
			tx_bit   <= 3'h0;
			tx_shift <= 8'h00;
		end else if (line_clear) begin
			tx_st <= hul_pkg::TX_IDLE; // RL12
			tx    <= 1'b1;
		end else begin
			case (tx_st)
				hul_pkg::TX_IDLE: begin
					tx <= 1'b1; // RL8 RL10
					if (tx_go) begin
						tx_shift <= tx_byte;
						tx       <= 1'b0; // RL4
						tx_st    <= hul_pkg::TX_START;
					end
				end
				hul_pkg::TX_START: begin
					if (tx_tick) begin
						tx       <= tx_shift[0]; // RL17
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_bit   <= 3'h0;
						tx_st    <= hul_pkg::TX_DATA;
					end
				end
				hul_pkg::TX_DATA: begin
					if (tx_tick) begin
						tx_bit <= tx_bit + 3'h1;
						if (tx_bit == 3'(hul_pkg::DATA_BITS - 1)) begin
							tx    <= 1'b1;
							tx_st <= hul_pkg::TX_STOP1;
						end else begin
							tx       <= tx_shift[0];
							tx_shift <= {1'b0, tx_shift[7:1]};
						end
					end
				end
				hul_pkg::TX_STOP1: begin
					if (tx_tick) begin
						tx_st <= setup[hul_pkg::SU_TWO_STOP] ?
							hul_pkg::TX_STOP2 : hul_pkg::TX_IDLE; // RL13
					end
				end
				hul_pkg::TX_STOP2: begin
					if (tx_tick) begin
						tx_st <= hul_pkg::TX_IDLE;
					end
				end
				default: tx_st <= hul_pkg::TX_IDLE;
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	tx_idle_high_a: assert property ((tx_st == hul_pkg::TX_IDLE && !tx_go) |=> tx) // RL8
		else $error("tx low while idle");
	start_low_a: assert property ($rose(tx_st == hul_pkg::TX_START) |-> !tx) // RL4
		else $error("start bit not low");
	stop_high_a: assert property ((tx_st == hul_pkg::TX_STOP1) |-> tx) // RL13
		else $error("stop bit not high");
	two_stop_a: assert property ((tx_st == hul_pkg::TX_STOP1 && tx_tick && !line_clear
		&& setup[hul_pkg::SU_TWO_STOP]) |=> (tx_st == hul_pkg::TX_STOP2) && tx) // RL13
		else $error("second stop bit missing");
	stack_tx_off_a: assert property ($past(setup[hul_pkg::SU_STACK])
		&& !$past(setup[hul_pkg::SU_STANDALONE]) |-> !tx_oe && !tx_busy) // RL9
		else $error("stack device drives tx");
	stop_err_a: assert property ((rx_done && !rx_s) |=> stop_error_flag) // RL5
		else $error("stop error not flagged");
	clear_flag_a: assert property (line_clear |=> line_clear_seen_flag && sof_pend) // RL20
		else $error("line clear not recorded");
	clear_abort_a: assert property (line_clear |=> ##[0:1] tx && !tx_busy) // RL12
		else $error("line clear did not stop tx");
	half_duplex_a: assert property (tx_busy |-> rx_st == hul_pkg::RX_IDLE) // RL11
		else $error("rx active while transmitting");
	slow_debug_a: assert property (!setup[hul_pkg::SU_DEBUG] |-> bit_div == hul_pkg::BIT_FAST) // RL7
		else $error("slow rate outside debug");
	chain_sel_a: assert property (chain_port_enable == !$past(setup[hul_pkg::SU_STANDALONE])) // RL1
		else $error("chain enable mismatch");
	hold_wait_a: assert property ($rose(tx_busy) |-> $past(hold_cnt) == '0) // RL16
		else $error("tx started inside hold-off");

	two_stop_c: cover property (tx_st == hul_pkg::TX_STOP2 && tx_tick);
	clear_tx_c: cover property (line_clear && tx_busy);
	rx_byte_c:  cover property (rx_done && rx_good && rx_sof);
	stop_err_c: cover property (rx_done && !rx_good);

endmodule : hul_uart_link

// *** test/hul_host_model.sv ***
// host uart model: drives rx, samples tx
`timescale 1ns/10ps
module hul_host_model (
	input  wire logic hclk,
	output logic      rx,
	input  wire logic tx
);
	// ****************************************
	// host side of the link
	// ****************************************
	int  bitc = 50;
	time f_prev;
	time f_last;
	time t_end;

	initial rx = 1'b1;

	// lsb first, stop level chosen so a bad stop can be sent
	task automatic send(input logic [7:0] b, input logic stp);
		logic [9:0] fr;
		fr = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge hclk);
			rx <= fr[i];
			repeat (bitc - 1) @(posedge hclk);
		end
		@(posedge hclk);
		rx <= 1'b1;
		t_end = $time;
	endtask : send

	task automatic clr(input int n);
		@(posedge hclk);
		rx <= 1'b0;
		repeat (n * bitc) @(posedge hclk);
		rx <= 1'b1;
	endtask : clr

	// bit0 must be high so the low run is the start bit alone
	task automatic rd(output logic [7:0] b, output int lowc);
		int w;
		w = 0;
		lowc = 0;
		while (tx !== 1'b0 && w < 20000) begin
			@(posedge hclk);
			w++;
		end
		f_prev = f_last;
		f_last = $time;
		while (tx === 1'b0 && lowc < 1000) begin
			@(posedge hclk);
			lowc++;
		end
		repeat (bitc / 2) @(posedge hclk);
		for (int i = 0; i < 8; i++) begin
			b[i] = tx;
			repeat (bitc) @(posedge hclk);
		end
	endtask : rd
endmodule : hul_host_model

// *** test/testbench.sv ***
// self-checking bench for the host uart link layer
`timescale 1ns/10ps
module testbench;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        rx;
	logic        tx;
	logic        tx_oe;
	logic        chain_port_enable;
	logic        chain_gap_long;
	int          err_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	logic [31:0] d;
	logic [7:0]  b;
	int          n;

	hul_uart_link hul_uart_link_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx(rx),
		.tx(tx), .tx_oe(tx_oe), .chain_port_enable(chain_port_enable),
		.chain_gap_long(chain_gap_long));
	hul_host_model hul_host_model_inst (.hclk(hclk), .rx(rx), .tx(tx));

	// ****************************************
	// common tasks
	// ****************************************
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask : chk

	// single ahb-lite transfer, address held until hready
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= v;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask : bus

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string s);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		chk(r & m, e, s);
	endtask : rchk

	// a write while pending would be dropped, so wait for room
	task automatic txw(input logic [7:0] v);
		logic [31:0] r;
		r = 32'h1;
		for (int i = 0; i < 2000 && r[hul_pkg::ST_TX_PEND] !== 1'b0; i++)
			bus(hul_pkg::A_STAT, 1'b0, 32'h0, r);
		bus(hul_pkg::A_TXD, 1'b1, {24'h0, v}, r);
	endtask : txw

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		// tx_oe leaves its reset value one edge after release; other outputs keep theirs
		repeat (2) @(posedge hclk);
		chk({hreadyout, hresp}, 2'b10, "bus ready okay");
		chk(tx, 1'b1, "tx idle");
		chk(tx_oe, 1'b1, "tx_oe base");
		chk(chain_port_enable, 1'b1, "chain on");
		rchk(hul_pkg::A_SETUP, 32'hFFFFFFFF, 32'h20, "setup reset");
		rchk(hul_pkg::A_HOLD, 32'hFFFFFFFF, 32'h1, "hold reset");
		rchk(hul_pkg::A_FAULT, 32'hFFFFFFFF, 32'h0, "fault reset");
		rchk(8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped");
		bus(hul_pkg::A_DADDR, 1'b1, 32'hFF, d);
		rchk(hul_pkg::A_DADDR, 32'hFFFFFFFF, 32'h3F, "addr width");
		$display("test reset done");
	endtask : t_reset

	task automatic t_tx;
		logic [7:0] b1;
		logic [7:0] b2;
		int         l1;
		int         l2;
		for (int k = 0; k < 2; k++) begin
			bus(hul_pkg::A_SETUP, 1'b1, k ? 32'h22 : 32'h20, d);
			fork
				begin txw(8'h55); txw(8'hA5); end
				begin hul_host_model_inst.rd(b1, l1); hul_host_model_inst.rd(b2, l2); end
			join
			chk(b1, 8'h55, "tx byte 1");
			chk(b2, 8'hA5, "tx byte 2");
			chk(l1, 50, "bit period");
			n = int'((hul_host_model_inst.f_last - hul_host_model_inst.f_prev) / 20);
			chk(n >= 500 + 50 * k && n <= 504 + 50 * k, 1'b1, "char spacing");
			chk(chain_gap_long, k[0], "gap select");
		end
		$display("test tx done");
	endtask : t_tx

	task automatic t_slow;
		for (int k = 0; k < 2; k++) begin
			bus(hul_pkg::A_SETUP, 1'b1, k ? 32'h38 : 32'h30, d);
			hul_host_model_inst.bitc = k ? 200 : 50;
			fork
				txw(8'h55);
				hul_host_model_inst.rd(b, n);
			join
			chk(n, k ? 200 : 50, "slow rate gate");
		end
		hul_host_model_inst.bitc = 50;
		bus(hul_pkg::A_SETUP, 1'b1, 32'h20, d);
		$display("test slow done");
	endtask : t_slow

	task automatic t_rx;
		// the last slow byte is still in its stop bit; rx would be ignored
		repeat (200) @(posedge hclk);
		hul_host_model_inst.send(8'hC3, 1'b1);
		repeat (20) @(posedge hclk);
		rchk(hul_pkg::A_RXD, 32'h3FF, 32'h3C3, "first rx byte");
		rchk(hul_pkg::A_RXD, 32'h100, 32'h0, "valid cleared");
		hul_host_model_inst.send(8'h5A, 1'b1);
		repeat (20) @(posedge hclk);
		rchk(hul_pkg::A_RXD, 32'h3FF, 32'h15A, "second rx byte");
		hul_host_model_inst.send(8'h81, 1'b0);
		repeat (20) @(posedge hclk);
		rchk(hul_pkg::A_FAULT, 32'h1, 32'h1, "stop error");
		bus(hul_pkg::A_FAULT, 1'b1, 32'h1, d);
		rchk(hul_pkg::A_FAULT, 32'h1, 32'h0, "stop error w1c");
		bus(hul_pkg::A_RXD, 1'b0, 32'h0, d);
		$display("test rx done");
	endtask : t_rx

	task automatic t_hold;
		bus(hul_pkg::A_HOLD, 1'b1, 32'h4, d);
		hul_host_model_inst.send(8'h42, 1'b1);
		fork
			txw(8'h55);
			hul_host_model_inst.rd(b, n);
		join
		n = int'((hul_host_model_inst.f_last - hul_host_model_inst.t_end) / 20);
		chk(n >= 120 && n <= 260, 1'b1, "hold-off wait");
		bus(hul_pkg::A_RXD, 1'b0, 32'h0, d);
		// rx arriving mid transmit must leave no byte behind
		fork
			txw(8'h55);
			hul_host_model_inst.rd(b, n);
			begin repeat (30) @(posedge hclk); hul_host_model_inst.send(8'h99, 1'b1); end
		join
		chk(b, 8'h55, "tx under rx");
		rchk(hul_pkg::A_RXD, 32'h100, 32'h0, "rx ignored in tx");
		$display("test hold done");
	endtask : t_hold

	task automatic t_clear;
		fork
			begin txw(8'hA5); txw(8'h55); end
			begin
				for (int i = 0; i < 200 && tx !== 1'b0; i++) @(posedge hclk);
				hul_host_model_inst.clr(16);
			end
		join
		n = 0;
		repeat (300) begin
			@(posedge hclk);
			if (tx !== 1'b1) n++;
		end
		chk(n, 0, "tx aborted");
		rchk(hul_pkg::A_FAULT, 32'h2, 32'h2, "clear seen");
		bus(hul_pkg::A_FAULT, 1'b1, 32'h3, d);
		repeat (100) @(posedge hclk);
		hul_host_model_inst.send(8'h3C, 1'b1);
		repeat (20) @(posedge hclk);
		rchk(hul_pkg::A_RXD, 32'h3FF, 32'h33C, "new frame");
		$display("test clear done");
	endtask : t_clear

	task automatic t_stack;
		bus(hul_pkg::A_SETUP, 1'b1, 32'h24, d);
		repeat (3) @(posedge hclk);
		chk(tx_oe, 1'b0, "stack tx off");
		rchk(hul_pkg::A_STAT, 32'h8, 32'h0, "stack uart off");
		hul_host_model_inst.send(8'h11, 1'b1);
		repeat (20) @(posedge hclk);
		rchk(hul_pkg::A_RXD, 32'h100, 32'h0, "stack rx ignored");
		chk(tx, 1'b1, "stack tx high");
		bus(hul_pkg::A_SETUP, 1'b1, 32'h21, d);
		repeat (3) @(posedge hclk);
		chk(chain_port_enable, 1'b0, "standalone");
		bus(hul_pkg::A_SETUP, 1'b1, 32'h20, d);
		repeat (3) @(posedge hclk);
		chk(chain_port_enable, 1'b1, "chain again");
		chk(tx_oe, 1'b1, "base tx on");
		$display("test stack done");
	endtask : t_stack

	// ****************************************
	// clock, timeout and main sequence
	// ****************************************
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// whole run needs about 10000 cycles
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			conclude();
		end
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_tx();
		t_slow();
		t_rx();
		t_hold();
		t_clear();
		t_stack();
		conclude();
	end
endmodule : testbench
